/* inc/abc_pkg.sv */
// constants, register map and phase encoding of the block cipher engine
// assumes a single 50 MHz clock and a plain address/strobe register port
package abc_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 11;            // byte address width
  localparam int DATA_W = 32;            // register port data width
  localparam int BLK_W  = 128;           // block and key width
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [10:0] OFS_CTRL    = 11'h540; // cipher_control
  localparam logic [10:0] OFS_DAT_LO  = 11'h548; // data_window first
  localparam logic [10:0] OFS_DAT_HI  = 11'h54B; // data_window last
  localparam logic [10:0] OFS_KEY_LO  = 11'h550; // key_bytes first
  localparam logic [10:0] OFS_KEY_HI  = 11'h55F; // key_bytes last
  localparam logic [10:0] OFS_STAT    = 11'h560; // event status, read only
  localparam logic [10:0] OFS_CLR     = 11'h564; // event clear, write only
  localparam logic [10:0] OFS_IEN     = 11'h568; // event enable
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_DIR  = 0;          // 1 decrypt, 0 encrypt
  localparam int CTRL_NEED = 1;          // input needed
  localparam int CTRL_RDY  = 2;          // output ready
  localparam int CTRL_CCM  = 7;          // chaining mode
  localparam int EV_DONE   = 0;          // operation finished
  localparam int EV_TAKEN  = 1;          // block accepted
  localparam int EV_W      = 2;          // number of events
  // ----------------------------------------
  // timing and sequencing
  // ----------------------------------------
  localparam logic [9:0] OP_LAST   = 10'd999; // 1000 cycles per block
  localparam logic [9:0] ENC_LAST  = 10'd10;  // last encrypt round step
  localparam logic [9:0] DKEY_LAST = 10'd10;  // last forward key step
  localparam logic [9:0] DEC_LOAD  = 10'd11;  // decrypt whitening step
  localparam logic [9:0] DEC_LAST  = 10'd21;  // last decrypt round step
  localparam logic [1:0] WORD_LAST = 2'd3;    // fourth window access
  // ----------------------------------------
  // field arithmetic constants
  // ----------------------------------------
  localparam logic [7:0]  GF_POLY  = 8'h1B;  // reduction polynomial
  localparam logic [7:0]  GF_ONE   = 8'h01;  // multiplicative unit
  localparam logic [7:0]  SBOX_C   = 8'h63;  // forward affine constant
  localparam logic [7:0]  ISBOX_C  = 8'h05;  // inverse affine constant
  localparam logic [7:0]  RC_FIRST = 8'h01;  // first round constant
  localparam logic [7:0]  RC_LAST  = 8'h36;  // tenth round constant
  localparam logic [7:0]  RC_TOP   = 8'h80;  // constant before wrap
  localparam logic [31:0] MIX_FWD  = 32'h02030101; // column mix
  localparam logic [31:0] MIX_INV  = 32'h0E0B0D09; // inverse column mix
  // ----------------------------------------
  // phase of the engine
  // ----------------------------------------
  typedef enum logic [1:0] {
    PH_FILL  = 2'b00,                    // waiting for four words
    PH_RUN   = 2'b01,                    // block in progress
    PH_DRAIN = 2'b11                     // result waiting for reads
  } abc_phase_e;
endpackage

/* design/abc_engine.sv */
// block cipher engine: 128-bit block, 128-bit key, register driven
// assumes one clock domain and a master that never overlaps strobes
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - one block takes 1000 cycles, no software help
// - control bit 0 selects decrypt or encrypt
// - result returned by four window reads
// - control bits 1 and 2 read only
// - input needed clears after fourth write
// - ready sets at finish, clears after reads
// - chaining off: result from block and key
// - control bit 7 chains previous ciphertext
// - reset shows need, not ready, encrypt, no chain
module abc_engine
  import abc_pkg::*;
(
  input  wire logic                      clk,     // 50 MHz clock
  input  wire logic                      rst_n,   // async reset
  input  wire logic [abc_pkg::ADDR_W-1:0] addr,   // byte address
  input  wire logic [abc_pkg::DATA_W-1:0] wr_data, // write data
  input  wire logic                      wr_en,   // write strobe
  input  wire logic                      rd_en,   // read strobe
  output logic      [abc_pkg::DATA_W-1:0] rd_data, // read data
  output logic                           irq      // event interrupt
);
  import abc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  // every flop of the engine sits in this one record, so a
  // single reset clears the whole block in one go
  typedef struct packed {
    abc_phase_e        phase;   // fill, run or drain
    logic              dir;     // direction bit
    logic              ccm;     // chaining bit
    logic              dir_op;  // direction of running block
    logic              ccm_op;  // chaining of running block
    logic [1:0]        wcnt;    // window writes seen
    logic [1:0]        rcnt;    // window reads seen
    logic [9:0]        cnt;     // cycle within the block
    logic [BLK_W-1:0]  key;     // key bytes
    logic [BLK_W-1:0]  blk;     // input block
    logic [BLK_W-1:0]  rk;      // running round key
    logic [7:0]        rc;      // running round constant
    logic [BLK_W-1:0]  st;      // cipher state
    logic [BLK_W-1:0]  res;     // result block
    logic [BLK_W-1:0]  prev;    // chaining value
    logic [EV_W-1:0]   stat;    // sticky events
    logic [EV_W-1:0]   ien;     // event enables
    logic              irq;     // interrupt flop
    logic [DATA_W-1:0] rd_data; // read data flop
  } abc_state_s;

  abc_state_s        q;         // registered state
  abc_state_s        next_q;    // next state
  logic [BLK_W-1:0]  k_fwd;     // next round key
  logic [BLK_W-1:0]  k_bwd;     // previous round key
  logic [BLK_W-1:0]  chain;     // chaining mask
  logic [EV_W-1:0]   ev;        // events this cycle
  logic [EV_W-1:0]   clr;       // clears this cycle
  logic              in_dat;    // address hits window
  logic              in_key;    // address hits key bytes
  logic [3:0]        kidx;      // key byte index

  // ----------------------------------------
  // field arithmetic
  // ----------------------------------------
  // byte arithmetic is computed, not looked up: more gates than a
  // table, but no constant arrays to keep in step with the maths
  // multiply by x
  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? GF_POLY : '0);
  endfunction

  // general multiply
  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = '0;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = xt(x);
    end
    return p;
  endfunction

  // inverse as x to the 254th, zero maps to zero
  // seven squarings and products; the deepest path of the engine
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = GF_ONE;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  // rotate a byte left
  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    logic [15:0] t;
    t = {b, b} << n;
    return t[15:8];
  endfunction

  // forward substitution
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] i;
    i = ginv(a);
    return i ^ rotl(i, 1) ^ rotl(i, 2) ^ rotl(i, 3) ^ rotl(i, 4) ^ SBOX_C;
  endfunction

  // inverse substitution
  function automatic logic [7:0] isbox(input logic [7:0] a);
    return ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ ISBOX_C);
  endfunction

  // ----------------------------------------
  // block transforms, byte n at bits 127-8n
  // ----------------------------------------
  // substitute four bytes of a rotated word
  function automatic logic [31:0] sub_rot(input logic [31:0] w);
    logic [31:0] r;
    r = {w[23:0], w[31:24]};
    return {sbox(r[31:24]), sbox(r[23:16]), sbox(r[15:8]), sbox(r[7:0])};
  endfunction

  // column mix, forward or inverse by coefficient set
  function automatic logic [127:0] mix(input logic [127:0] s,
                                       input logic [31:0]  m);
    logic [127:0] o;
    logic [7:0]   b;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        b = '0;
        for (int j = 0; j < 4; j++) begin
          b = b ^ gmul(m[31-8*((j-r+4)%4) -: 8], s[127-8*(j+4*c) -: 8]);
        end
        o[127-8*(r+4*c) -: 8] = b;
      end
    end
    return o;
  endfunction

  // one encrypt round
  // row shift folded into the byte pick, so no extra pass
  function automatic logic [127:0] enc_round(input logic [127:0] s,
                                             input logic [127:0] k,
                                             input logic         last);
    logic [127:0] o;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[127-8*(r+4*c) -: 8] = sbox(s[127-8*(r+4*((c+r)%4)) -: 8]);
      end
    end
    if (!last) begin
      o = mix(o, MIX_FWD);
    end
    return o ^ k;
  endfunction

  // one decrypt round
  // inverse row shift folded in; key added before the column unmix
  function automatic logic [127:0] dec_round(input logic [127:0] s,
                                             input logic [127:0] k,
                                             input logic         last);
    logic [127:0] o;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[127-8*(r+4*c) -: 8] = isbox(s[127-8*(r+4*((c+4-r)%4)) -: 8]);
      end
    end
    o = o ^ k;
    if (!last) begin
      o = mix(o, MIX_INV);
    end
    return o;
  endfunction

  // forward key step
  function automatic logic [127:0] key_next(input logic [127:0] k,
                                            input logic [7:0]   rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w0 = k[127:96] ^ sub_rot(k[31:0]) ^ {rc, 24'h000000};
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    return {w0, w1, w2, w3};
  endfunction

  // backward key step
  // decrypt walks the schedule back from round ten, so no
  // table of round keys has to be stored
  function automatic logic [127:0] key_prev(input logic [127:0] k,
                                            input logic [7:0]   rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w3 = k[31:0] ^ k[63:32];
    w2 = k[63:32] ^ k[95:64];
    w1 = k[95:64] ^ k[127:96];
    w0 = k[127:96] ^ sub_rot(w3) ^ {rc, 24'h000000};
    return {w0, w1, w2, w3};
  endfunction

  // round constant one step back
  // undoes xt, including the wrap through the reduction value
  function automatic logic [7:0] rc_back(input logic [7:0] rc);
    return (rc == GF_POLY) ? RC_TOP : {1'b0, rc[7:1]};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // bus decode, cipher sequence and events
  always_comb begin
    // hold everything by default; read data drops back to zero
    // unless a read is taken this cycle
    next_q         = q;
    next_q.rd_data = '0;
    ev             = '0;
    clr            = '0;
    k_fwd          = key_next(q.rk, q.rc);
    k_bwd          = key_prev(q.rk, q.rc);
    // chaining value only when chaining was on at start
    // chaining off: the mask is zero, so no earlier block leaks in
    chain  = q.ccm_op ? q.prev : '0;
    in_dat = (addr >= OFS_DAT_LO) && (addr <= OFS_DAT_HI);
    in_key = (addr >= OFS_KEY_LO) && (addr <= OFS_KEY_HI);
    kidx   = addr[3:0];

    // register writes
    if (wr_en) begin
      if (addr == OFS_CTRL) begin
        // need and ready bits ignore writes
        // a change here steers the next block, not the running one
        next_q.dir = wr_data[CTRL_DIR];
        next_q.ccm = wr_data[CTRL_CCM];
      end else if (in_dat) begin
        // words only taken while input is needed
        if (q.phase == PH_FILL) begin
          next_q.blk[32*q.wcnt +: 32] = wr_data;
          next_q.wcnt = q.wcnt + 2'd1;
          if (q.wcnt == WORD_LAST) begin
            // fourth word: start at once, need clears
            next_q.phase  = PH_RUN;
            next_q.cnt    = '0;
            next_q.dir_op = q.dir;
            next_q.ccm_op = q.ccm;
            ev[EV_TAKEN]  = 1'b1;
          end
        end
      end else if (in_key) begin
        // key bytes writable any time
        next_q.key[127-8*kidx -: 8] = wr_data[7:0];
      end else if (addr == OFS_CLR) begin
        clr = wr_data[EV_W-1:0];
      end else if (addr == OFS_IEN) begin
        next_q.ien = wr_data[EV_W-1:0];
      end
    end

    // register reads, data valid the next cycle
    if (rd_en) begin
      if (addr == OFS_CTRL) begin
        next_q.rd_data[CTRL_DIR]  = q.dir;
        next_q.rd_data[CTRL_NEED] = (q.phase == PH_FILL);
        next_q.rd_data[CTRL_RDY]  = (q.phase == PH_DRAIN);
        next_q.rd_data[CTRL_CCM]  = q.ccm;
      end else if (in_dat) begin
        next_q.rd_data = q.res[32*q.rcnt +: 32];
        // only reads of a ready result advance
        // early reads see the previous result; they do not count
        if (q.phase == PH_DRAIN) begin
          next_q.rcnt = q.rcnt + 2'd1;
          if (q.rcnt == WORD_LAST) begin
            next_q.phase = PH_FILL;
          end
        end
      end else if (in_key) begin
        next_q.rd_data[7:0] = q.key[127-8*kidx -: 8];
      end else if (addr == OFS_STAT) begin
        next_q.rd_data[EV_W-1:0] = q.stat;
      end else if (addr == OFS_IEN) begin
        next_q.rd_data[EV_W-1:0] = q.ien;
      end
    end

    // cipher sequence, one step per cycle
    // the rounds end early; the remaining cycles only count, so the
    // block time is the same for either direction and any data
    if (q.phase == PH_RUN) begin
      next_q.cnt = q.cnt + 10'd1;
      if (!q.dir_op) begin
        // encrypt: whitening then ten rounds
        if (q.cnt == '0) begin
          next_q.st = q.blk ^ chain ^ q.key;
          next_q.rk = q.key;
          next_q.rc = RC_FIRST;
        end else if (q.cnt <= ENC_LAST) begin
          next_q.rk = k_fwd;
          next_q.rc = xt(q.rc);
          next_q.st = enc_round(q.st, k_fwd, q.cnt == ENC_LAST);
        end
      end else begin
        // decrypt: run key forward, then rounds back
        if (q.cnt == '0) begin
          next_q.rk = q.key;
          next_q.rc = RC_FIRST;
        end else if (q.cnt <= DKEY_LAST) begin
          // park the constant on round ten for the walk back
          next_q.rk = k_fwd;
          next_q.rc = (q.cnt == DKEY_LAST) ? RC_LAST : xt(q.rc);
        end else if (q.cnt == DEC_LOAD) begin
          next_q.st = q.blk ^ q.rk;
        end else if (q.cnt <= DEC_LAST) begin
          next_q.rk = k_bwd;
          next_q.rc = rc_back(q.rc);
          next_q.st = dec_round(q.st, k_bwd, q.cnt == DEC_LAST);
        end
      end
      // fixed length: finish on the last cycle
      if (q.cnt == OP_LAST) begin
        next_q.phase  = PH_DRAIN;
        next_q.rcnt   = '0;
        next_q.res    = q.dir_op ? (q.st ^ chain) : q.st;
        // chaining value is always the ciphertext of this block
        next_q.prev   = q.dir_op ? q.blk : q.st;
        ev[EV_DONE]   = 1'b1;
      end
    end

    // sticky events, a new event beats its clear
    // interrupt uses the next status so it rises with the bit
    next_q.stat = (q.stat & ~clr) | ev;
    next_q.irq  = |(next_q.stat & next_q.ien);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // all-zero reset gives need set, encrypt, no chain
  // the only process that writes state; outputs come straight off it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // both outputs are plain flop bits, no logic after the register
  assign rd_data = q.rd_data;   // read data flop
  assign irq     = q.irq;       // interrupt flop

endmodule

/* tb/abc_engine_sva.sv */
// checker for the cipher engine register port and interrupt
// assumes binding to abc_engine and a single clock domain
`timescale 1ns/1ps
module abc_engine_sva
  import abc_pkg::*;
(
  input wire logic                       clk,     // clock
  input wire logic                       rst_n,   // async reset
  input wire logic [abc_pkg::ADDR_W-1:0] addr,    // byte address
  input wire logic [abc_pkg::DATA_W-1:0] wr_data, // write data
  input wire logic                       wr_en,   // write strobe
  input wire logic                       rd_en,   // read strobe
  input wire logic [abc_pkg::DATA_W-1:0] rd_data, // read data
  input wire logic                       irq      // interrupt
);
  // ----------------------------------------
  // mirrored state
  // ----------------------------------------
  abc_phase_e ph;        // engine phase
  logic [1:0] wn;        // window writes taken
  logic [1:0] rn;        // window reads taken
  logic [9:0] tm;        // cycles since start
  logic [7:0] ctl;       // direction and chaining bits
  logic [1:0] st;        // event status
  logic [1:0] en;        // event enable
  logic [7:0] key [16];  // key bytes
  wire        win  = addr >= OFS_DAT_LO && addr <= OFS_DAT_HI; // window hit
  wire        kwin = addr >= OFS_KEY_LO && addr <= OFS_KEY_HI; // key hit
  wire        take = wr_en && win && ph == PH_FILL;            // word accepted
  wire        fin  = ph == PH_RUN && tm == OP_LAST;            // block ends
  wire [31:0] exp_ctl = {24'h0, ctl[7], 4'h0, ph == PH_DRAIN, ph == PH_FILL, ctl[0]};
  wire [7:0]  exp_key = key[addr[3:0]];                        // addressed key byte
  wire        known = win || kwin || addr == OFS_CTRL || addr == OFS_STAT
                      || addr == OFS_CLR || addr == OFS_IEN;   // mapped address
  // mirror of phase, status and written registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph  <= PH_FILL;
      wn  <= '0;
      rn  <= '0;
      tm  <= '0;
      ctl <= '0;
      st  <= '0;
      en  <= '0;
      for (int i = 0; i < 16; i++) key[i] <= '0;
    end else begin
      if (wr_en && addr == OFS_CTRL) ctl <= wr_data[7:0] & 8'h81;
      if (wr_en && kwin) key[addr[3:0]] <= wr_data[7:0];
      if (wr_en && addr == OFS_IEN) en <= wr_data[1:0];
      // done is bit 0, block taken bit 1; a new event beats its clear
      st <= (st & ~(wr_en && addr == OFS_CLR ? wr_data[1:0] : 2'h0))
            | {take && wn == WORD_LAST, fin};
      if (take) wn <= wn + 2'h1;
      if (take && wn == WORD_LAST) ph <= PH_RUN;
      tm <= (ph == PH_RUN) ? tm + 10'h1 : '0;
      if (fin) ph <= PH_DRAIN;
      if (rd_en && win && ph == PH_DRAIN) rn <= rn + 2'h1;
      if (rd_en && win && ph == PH_DRAIN && rn == WORD_LAST) ph <= PH_FILL;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ctrl_tracks: assert property (
    rd_en && addr == OFS_CTRL |=> rd_data == $past(exp_ctl))
    else $error("control flags differ from expected");
  a_rd_idle_zero: assert property (
    rd_en ##1 !rd_en |=> rd_data == '0)
    else $error("read data not cleared after one cycle");
  a_key_readback: assert property (
    rd_en && kwin |=> rd_data == {24'h0, $past(exp_key)})
    else $error("key byte read back wrong");
  a_stat_tracks: assert property (
    rd_en && addr == OFS_STAT |=> rd_data == {30'h0, $past(st)})
    else $error("event status wrong");
  a_ien_readback: assert property (
    rd_en && addr == OFS_IEN |=> rd_data == {30'h0, $past(en)})
    else $error("event enable read back wrong");
  a_irq_level: assert property (
    irq == |(st & en))
    else $error("interrupt level wrong");
  a_clr_reads_zero: assert property (
    rd_en && addr == OFS_CLR |=> rd_data == '0)
    else $error("clear register read not zero");
  a_unmapped_zero: assert property (
    rd_en && !known |=> rd_data == '0)
    else $error("unmapped read not zero");
  c_block_done: cover property (fin);
  c_irq_rise: cover property ($rose(irq));
  c_chain_start: cover property (take && wn == WORD_LAST && ctl[7]);
endmodule

bind abc_engine abc_engine_sva chk_u (.clk, .rst_n, .addr, .wr_data, .wr_en,
                                      .rd_en, .rd_data, .irq);

/* tb/abc_master.sv */
// register port master standing in for the cpu or dma channel
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module abc_master
  import abc_pkg::*;
(
  input  wire logic                       clk,     // clock
  output logic      [abc_pkg::ADDR_W-1:0] addr,    // byte address
  output logic      [abc_pkg::DATA_W-1:0] wr_data, // write data
  output logic                            wr_en,   // write strobe
  output logic                            rd_en,   // read strobe
  input  wire logic [abc_pkg::DATA_W-1:0] rd_data  // read data
);
  // idle bus at time zero
  initial begin
    addr    = '0;
    wr_data = '0;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end
  // one write cycle; released lines show inverted values
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
    addr    <= ~a;
    wr_data <= ~d;
    @(posedge clk);
  endtask
  // one read cycle; data taken at the edge after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    addr  <= ~a;
    @(posedge clk);
    d = rd_data;
  endtask
endmodule

/* tb/tb_abc_engine.sv */
// self-checking bench for the cipher engine register port
// assumes the master model abc_master and the bound checker
`timescale 1ns/1ps
module tb_abc_engine;
  import abc_pkg::*;
  // ----------------------------------------
  // signals and vectors
  // ----------------------------------------
  logic        clk;        // 50 MHz clock
  logic        rst_n;      // async reset
  logic [10:0] addr;       // byte address
  logic [31:0] wr_data;    // write data
  logic [31:0] rd_data;    // read data
  logic        wr_en;      // write strobe
  logic        rd_en;      // read strobe
  logic        irq;        // interrupt
  logic [31:0] rv;         // last read value
  int          n_mismatch; // mismatches
  int          cmp_count;  // comparisons
  int          cyc = 0;    // cycle counter
  localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF; // plaintext
  localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A; // ciphertext
  abc_master m_u (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                  .rd_en(rd_en), .rd_data(rd_data));
  abc_engine dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
                    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [10:0] a, input logic [31:0] e);
    m_u.rd(a, rv);
    cmp32(rv, e);
  endtask
  // one block: control, four words, wait for ready, four reads
  task automatic blk(input logic [7:0] c, input logic [127:0] din, input logic [127:0] exp);
    int n;
    m_u.wr(OFS_CTRL, {24'h0, c});
    for (int i = 0; i < 4; i++) m_u.wr(OFS_DAT_LO + 11'(i), din[32*i +: 32]);
    chk(OFS_CTRL, {24'h0, c});
    m_u.wr(OFS_DAT_LO, 32'hFFFFFFFF);
    n = 0;
    do begin
      m_u.rd(OFS_CTRL, rv);
      n++;
    end while (rv[2] !== 1'b1 && n < 600);
    cmp32(rv, {24'h0, c | 8'h04});
    // ready first shows on poll 499: fourth word taken at edge E, polls
    // strobe at E+4+2n, and the finish edge is E+1000
    cmp32(n, 32'd499);
    for (int i = 0; i < 4; i++) chk(OFS_DAT_LO + 11'(i), exp[32*i +: 32]);
    chk(OFS_CTRL, {24'h0, c | 8'h02});
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk(OFS_CTRL, 32'h2);
    chk(OFS_KEY_LO, 32'h0);
    cmp1(irq, 1'b0);
    m_u.wr(OFS_CTRL, 32'h6);
    chk(OFS_CTRL, 32'h2);
    for (int i = 0; i < 16; i++) m_u.wr(OFS_KEY_LO + 11'(i), {24'h0, 8'(i)});
    chk(OFS_KEY_HI, 32'hF);
    chk(11'h570, 32'h0);
    m_u.wr(OFS_IEN, 32'h1);
    chk(OFS_IEN, 32'h1);
    blk(8'h00, PT, CT);
    cmp1(irq, 1'b1);
    chk(OFS_STAT, 32'h3);
    m_u.wr(OFS_CLR, 32'h3);
    chk(OFS_STAT, 32'h0);
    chk(OFS_CLR, 32'h0);
    cmp1(irq, 1'b0);
    m_u.wr(OFS_IEN, 32'h0);
    blk(8'h01, CT, PT);
    cmp1(irq, 1'b0);
    chk(OFS_STAT, 32'h3);
    blk(8'h81, CT, PT ^ CT);
    blk(8'h01, CT, PT);
    summarize;
  end
endmodule
